/* design/bbs_host.sv */
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - keep address stable during write
// - deassert for recovery before next cycle
// - data valid before end, held after
// - output enable high during writes
// - keep deselected while supply rises
module bbs_host #(
  parameter int POWER_UP_RECOVERY_CYC = bbs_pkg::POWER_UP_RECOVERY_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_valid,
  input wire bbs_pkg::bbs_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [bbs_pkg::DATA_W-1:0] rsp_data,
  input wire logic power_fail,
  output logic power_ok,
  output logic [bbs_pkg::ADDR_W-1:0] address_pins,
  output bbs_pkg::bbs_ctl_t ctl,
  input wire logic [bbs_pkg::DATA_W-1:0] data_pins_in,
  output logic [bbs_pkg::DATA_W-1:0] data_pins_out,
  output logic data_pins_oe
);
  localparam int CW = bbs_pkg::CNT_W;

  bbs_pkg::bbs_state_t state_q, state_d;
  logic [bbs_pkg::ADDR_W-1:0] addr_q;
  logic [bbs_pkg::DATA_W-1:0] rdata_q, dout_q, dout_d;
  bbs_pkg::bbs_ctl_t ctl_q, ctl_d;
  logic drive_q, rsp_q, ready_q, pok_q;
  logic tmr_load, tmr_done, pu_load, pu_done;
  logic [CW-1:0] tmr_val;

  wire take = (state_q == bbs_pkg::ST_IDLE) && req_valid && pok_q;
  wire access_end = (state_q == bbs_pkg::ST_READ) && tmr_done;
  wire write_end = (state_q == bbs_pkg::ST_WRITE) && tmr_done;
  wire hold_end = (state_q == bbs_pkg::ST_HOLD) && tmr_done;
  wire fail_now = power_fail && (state_q != bbs_pkg::ST_FAIL);

  always_comb begin
    state_d = state_q;
    tmr_load = 1'b0;
    tmr_val = '0;
    unique case (state_q)
      bbs_pkg::ST_IDLE: begin
        if (take) begin
          tmr_load = 1'b1;
          tmr_val = req.write ? CW'(bbs_pkg::STROBE_CYC) : CW'(bbs_pkg::ACCESS_CYC);
          state_d = req.write ? bbs_pkg::ST_WRITE : bbs_pkg::ST_READ;
        end
      end
      bbs_pkg::ST_READ: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_val = CW'(bbs_pkg::RELEASE_CYC);
          state_d = bbs_pkg::ST_RECOVER;
        end
      end
      bbs_pkg::ST_WRITE: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_val = CW'(bbs_pkg::HOLD_CYC);
          state_d = bbs_pkg::ST_HOLD;
        end
      end
      bbs_pkg::ST_HOLD: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_val = CW'(bbs_pkg::RECOVERY_CYC);
          state_d = bbs_pkg::ST_RECOVER;
        end
      end
      bbs_pkg::ST_RECOVER: begin
        if (tmr_done) begin
          state_d = bbs_pkg::ST_IDLE;
        end
      end
      bbs_pkg::ST_FAIL: begin
        if (pu_done && !power_fail) begin
          state_d = bbs_pkg::ST_IDLE;
        end
      end
      default: state_d = bbs_pkg::ST_IDLE;
    endcase
    if (fail_now) begin
      state_d = bbs_pkg::ST_FAIL;
    end
  end

  bbs_timer #(.W(CW)) u_tmr (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(tmr_load),
    .value(tmr_val),
    .done(tmr_done)
  );

  assign pu_load = power_fail || rst;
  bbs_timer #(.W(32)) u_pwr (
    .clk_sys(clk_sys),
    .rst(1'b0),
    .load(pu_load),
    .value(32'(POWER_UP_RECOVERY_CYC)),
    .done(pu_done)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= bbs_pkg::ST_FAIL;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addr_q <= '0;
    end else if (take) begin
      addr_q <= req.addr;
    end
  end

  wire sel_d = (state_d == bbs_pkg::ST_READ) || (state_d == bbs_pkg::ST_WRITE);
  wire wr_d = (state_d == bbs_pkg::ST_WRITE);
  wire oe_d = (state_d == bbs_pkg::ST_READ);
  wire drive_d = wr_d || (state_d == bbs_pkg::ST_HOLD);
  // pin levels decoded before the register, so pins never glitch
  assign ctl_d = {!sel_d, sel_d, !oe_d, !wr_d};
  // write byte taken with the request, zero while not driving
  assign dout_d = !drive_d ? '0 : (take ? req.wdata : dout_q);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // deselected, outputs off, strobe high
      ctl_q <= 4'hB;
      dout_q <= '0;
      drive_q <= 1'b0;
      rsp_q <= 1'b0;
      rdata_q <= '0;
      ready_q <= 1'b0;
      pok_q <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      dout_q <= dout_d;
      drive_q <= drive_d;
      rsp_q <= access_end && !fail_now;
      if (access_end) begin
        rdata_q <= data_pins_in;
      end
      ready_q <= (state_d == bbs_pkg::ST_IDLE) && (state_q == bbs_pkg::ST_IDLE || state_d != state_q)
                 && !power_fail && pu_done;
      pok_q <= !power_fail && pu_done;
    end
  end

  assign ctl = ctl_q;
  assign address_pins = addr_q;
  // own drive only while device released
  assign data_pins_out = dout_q;
  assign data_pins_oe = drive_q;
  assign req_ready = ready_q;
  assign rsp_valid = rsp_q;
  assign rsp_data = rdata_q;
  assign power_ok = pok_q;
endmodule : bbs_host
`default_nettype wire

/* design/bbs_pkg.sv */
package bbs_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  // cycle time, ns
  localparam int CLK_PERIOD_NS = 50;
  // least times in ns, rounded up to cycles
  localparam int ACCESS_NS = 150;
  localparam int STROBE_NS = 130;
  localparam int SETUP_DATA_NS = 70;
  localparam int HOLD_NS = 10;
  localparam int RECOVERY_NS = 10;
  localparam int RELEASE_NS = 70;
  localparam int POWER_UP_RECOVERY_NS = 2000000;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYC = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_CYC = (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWER_UP_RECOVERY_CYC = (POWER_UP_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bbs_req_t;

  typedef struct packed {
    logic chip_select_low_active;
    logic chip_select_high_active;
    logic output_enable_n;
    logic write_strobe_n;
  } bbs_ctl_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_WRITE = 3'b010,
    ST_HOLD = 3'b011,
    ST_RECOVER = 3'b100,
    ST_FAIL = 3'b101
  } bbs_state_t;
endpackage : bbs_pkg

/* design/bbs_timer.sv */
`timescale 1ns/10ps
`default_nettype none
// loadable down counter; done while zero
module bbs_timer #(
  parameter int W = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  assign cnt_d = load ? value : (cnt_q != '0 ? cnt_q - W'(1) : cnt_q);
  assign done = (cnt_q == '0);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : bbs_timer
`default_nettype wire

/* dv/bbs_sram_model.sv */
`timescale 1ns/10ps
`default_nettype none
module bbs_sram_model #(
  parameter int ACC_NS = 140
) (
  input wire logic pwr_fail,
  input wire logic [bbs_pkg::ADDR_W-1:0] address_pins,
  input wire bbs_pkg::bbs_ctl_t ctl,
  input wire logic [bbs_pkg::DATA_W-1:0] data_pins_out,
  output logic [bbs_pkg::DATA_W-1:0] data_pins_in
);
  logic [bbs_pkg::DATA_W-1:0] mem [2**bbs_pkg::ADDR_W];
  wire sel = !ctl.chip_select_low_active && ctl.chip_select_high_active && !pwr_fail;
  wire rd = sel && ctl.write_strobe_n && !ctl.output_enable_n;
  wire wr = sel && !ctl.write_strobe_n;
  initial data_pins_in = 8'hA5;
  always @(negedge wr) mem[address_pins] = data_pins_out;
  always @(rd or address_pins) begin
    data_pins_in = ~data_pins_in;
    #ACC_NS if (rd) data_pins_in = mem[address_pins];
  end
endmodule : bbs_sram_model
`default_nettype wire

/* dv/bbs_host_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module bbs_host_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic power_fail,
  input wire logic power_ok,
  input wire logic [bbs_pkg::ADDR_W-1:0] address_pins,
  input wire bbs_pkg::bbs_ctl_t ctl,
  input wire logic [bbs_pkg::DATA_W-1:0] data_pins_out,
  input wire logic data_pins_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire sel = !ctl.chip_select_low_active && ctl.chip_select_high_active;
  wire wr = sel && !ctl.write_strobe_n;
  sequence wr_body;
    (wr && data_pins_oe) [*4];
  endsequence
  sequence wr_tail;
    (!sel && ctl.write_strobe_n && data_pins_oe) [*2] ##1 !data_pins_oe;
  endsequence
  wr_shape_a: assert property (disable iff (rst || power_fail) $rose(wr) |-> wr_body ##1 wr_tail)
    else $error("write cycle shape wrong");
  addr_hold_a: assert property ($past(wr) |-> $stable(address_pins))
    else $error("address moved in write");
  data_hold_a: assert property ($past(data_pins_oe) && data_pins_oe |-> $stable(data_pins_out))
    else $error("write data moved");
  oe_high_a: assert property (data_pins_oe || wr |-> ctl.output_enable_n)
    else $error("output enable low in write");
  recovery_gap_a: assert property ($fell(sel) |-> !sel [*2])
    else $error("recovery gap short");
  pf_quiet_a: assert property (!power_ok |-> !sel && !data_pins_oe)
    else $error("selected while power bad");
endmodule : bbs_host_chk
bind bbs_host bbs_host_chk i_chk (.clk_sys(clk_sys), .rst(rst), .power_fail(power_fail), .power_ok(power_ok),
  .address_pins(address_pins), .ctl(ctl), .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe));
`default_nettype wire

/* dv/bbs_host_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module bbs_host_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic power_fail = 1'b0;
  bbs_pkg::bbs_req_t req = '0;
  logic req_ready, rsp_valid, power_ok, data_pins_oe;
  logic [7:0] rsp_data, data_pins_in, data_pins_out;
  logic [12:0] address_pins;
  bbs_pkg::bbs_ctl_t ctl;
  int miscompares = 0;
  int checks_done = 0;
  int rsp_seen = 0;
  logic [12:0] ad [3] = '{13'h0000, 13'h1FFF, 13'h0AAA};
  logic [7:0] dt [3] = '{8'h3C, 8'hC3, 8'h5A};
  always #25 clk_sys = ~clk_sys;
  bbs_host #(.POWER_UP_RECOVERY_CYC(4)) i_dut (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .power_fail(power_fail),
    .power_ok(power_ok), .address_pins(address_pins), .ctl(ctl), .data_pins_in(data_pins_in),
    .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe));
  bbs_sram_model i_mem (.pwr_fail(power_fail), .address_pins(address_pins), .ctl(ctl),
    .data_pins_out(data_pins_out), .data_pins_in(data_pins_in));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // holds the request until the cycle starts; ab aborts it by supply fail
  task automatic go(input logic w, input logic [12:0] a, input logic [7:0] d, input logic ab);
    int n;
    n = 0;
    rsp_seen = 0;
    req = {w, a, d};
    req_valid = 1'b1;
    while (ctl.chip_select_high_active !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    chk(8'(n < 200), 8'h01);
    req_valid = 1'b0;
    power_fail = ab;
    while (req_ready !== 1'b1 && n < 400 && !ab) begin
      @(negedge clk_sys);
      n++;
      if (rsp_valid === 1'b1) rsp_seen++;
    end
    chk(8'(n < 400), 8'h01);
  endtask : go
  task automatic test_reset();
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    chk({power_ok, ctl.chip_select_high_active, data_pins_oe}, 8'h00);
    $display("reset test done");
  endtask : test_reset
  task automatic test_write_read();
    for (int i = 0; i < 3; i++) begin
      go(1'b1, ad[i], dt[i], 1'b0);
      chk(8'(rsp_seen), 8'h00);
    end
    for (int i = 0; i < 3; i++) begin
      go(1'b0, ad[i], 8'h00, 1'b0);
      chk(rsp_data, dt[i]);
      chk(8'(rsp_seen), 8'h01);
    end
    $display("write read test done");
  endtask : test_write_read
  task automatic test_power_fail();
    go(1'b1, 13'h0101, 8'hEE, 1'b1);
    @(negedge clk_sys);
    req_valid = 1'b1;
    repeat (6) begin
      @(negedge clk_sys);
      chk({ctl.chip_select_high_active, data_pins_oe, power_ok}, 8'h00);
    end
    req_valid = 1'b0;
    power_fail = 1'b0;
    @(negedge clk_sys);
    chk(power_ok, 8'h00);
    go(1'b0, 13'h1FFF, 8'h00, 1'b0);
    chk(rsp_data, 8'hC3);
    $display("power fail test done");
  endtask : test_power_fail
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    test_reset();
    test_write_read();
    test_power_fail();
    report_and_stop();
  end
  initial begin
    #100us;
    miscompares++;
    report_and_stop();
  end
endmodule : bbs_host_tb
`default_nettype wire
